// *** design/tmc_alarm.v ***
`timescale 1ns/100ps
`include "tmc_map.vh"
module tmc_alarm #(
  parameter TW = `TMC_TEMP_W + 2
) (
  input wire clock_in, // System clock
  input wire resetn_in, // Synchronous reset, active low
  input wire clear_in, // Channel reset from a configuration write
  input wire sample_in, // New corrected sample present
  input wire signed [TW-1:0] temp_in, // Offset-corrected temperature, quarter degrees
  input wire [`TMC_TH_W-1:0] threshold_in, // Threshold, whole degrees
  input wire [`TMC_HYST_W-1:0] hysteresis_in, // Hysteresis, whole degrees
  input wire [`TMC_FILT_W-1:0] depth_code_in, // Filter depth minus one
  output reg alarm_out // Alarm: temperature above threshold
);
  wire signed [TW-1:0] thr_q;
  wire signed [TW-1:0] hys_q;
  wire signed [TW-1:0] limit;
  wire above;
  reg [`TMC_FILT_W-1:0] run;
  reg [`TMC_FILT_W-1:0] next_run;
  reg next_alarm;

  assign thr_q = {{(TW-`TMC_TH_W-`TMC_DEG_SHIFT){threshold_in[`TMC_TH_W-1]}}, threshold_in,
                  {`TMC_DEG_SHIFT{1'b0}}};
  assign hys_q = {{(TW-`TMC_HYST_W-`TMC_DEG_SHIFT){hysteresis_in[`TMC_HYST_W-1]}}, hysteresis_in,
                  {`TMC_DEG_SHIFT{1'b0}}};
  // Once asserted, the release point moves by the hysteresis; negative values suit over-temperature use
  assign limit = alarm_out ? (thr_q + hys_q) : thr_q;
  assign above = (temp_in > limit);

  always @* begin
    next_run = run;
    next_alarm = alarm_out;
    if (sample_in) begin
      if (above == alarm_out) begin
        next_run = {`TMC_FILT_W{1'b0}};
      end else if (run == depth_code_in) begin
        next_alarm = above;
        next_run = {`TMC_FILT_W{1'b0}};
      end else begin
        next_run = run + 1'b1;
      end
    end
  end

  always @(posedge clock_in) begin
    if (!resetn_in || clear_in) begin
      run <= {`TMC_FILT_W{1'b0}};
      alarm_out <= 1'b0;
    end else begin
      run <= next_run;
      alarm_out <= next_alarm;
    end
  end
endmodule

// *** design/tmc_channel.v ***
`timescale 1ns/100ps
`include "tmc_map.vh"
// Contract
// - Add 9-bit quarter-degree offset to measurement for readout and both alarms.
// - Offset is two's complement, 0x100 most negative, 0x0FF most positive.
// - Two independent comparators A and B with signed 9-bit whole-degree thresholds.
// - Diode fault detection only on remote channels, never the internal one.
// - Fault readout fixed: short 0x3FF, open 0x401; polarity bit swaps them.
// - Exponential averaging before readout, coefficient 1, 8 or 16; code 11 invalid.
// - Each comparator has a 4-bit filter, depth equals field plus one.
// - Each comparator has signed 7-bit whole-degree hysteresis.
// - Filtered corrected temperature of each channel is readable by the host.
// - Any configuration write resets that channel's monitoring circuit.
// - Channel settings span nine byte-wide configuration registers.
module tmc_channel #(
  parameter REMOTE = 1
) (
  input wire clock_in, // System clock, 50 MHz
  input wire resetn_in, // Synchronous reset, active low
  input wire config_write_in, // Pulse: any configuration byte of this channel written
  input wire sample_valid_in, // Pulse: new raw measurement
  input wire [`TMC_TEMP_W-1:0] sample_in, // Raw temperature, signed quarter degrees
  input wire diode_open_in, // Remote diode open detected
  input wire diode_short_in, // Remote diode short detected
  input wire [`TMC_OFF_W-1:0] offset_in, // Offset code
  input wire [`TMC_TH_W-1:0] threshold_a_in, // Threshold for comparator A
  input wire [`TMC_TH_W-1:0] threshold_b_in, // Threshold for comparator B
  input wire fault_read_polarity_in, // Swaps the fault readout codes
  input wire [1:0] average_coefficient_in, // Averaging selector
  input wire [`TMC_FILT_W-1:0] alarm_filter_a_in, // Filter depth code A
  input wire [`TMC_FILT_W-1:0] alarm_filter_b_in, // Filter depth code B
  input wire [`TMC_HYST_W-1:0] hysteresis_a_in, // Hysteresis for A
  input wire [`TMC_HYST_W-1:0] hysteresis_b_in, // Hysteresis for B
  output reg [`TMC_TEMP_W-1:0] temperature_out, // Readout value for I2C
  output reg readout_valid_out, // Pulse: readout updated
  output reg fault_out, // Readout is a fault code
  output reg alarm_comparator_a_out, // Comparator A alarm
  output reg alarm_comparator_b_out // Comparator B alarm
);
  localparam TW = `TMC_TEMP_W + 2;
  localparam AW = TW + `TMC_ACC_FRAC;
  // Clamp limits sit one step inside the fault codes, kept at the working width
  localparam signed [TW-1:0] SAT_HI = {{(TW-`TMC_TEMP_W){1'b0}}, `TMC_CODE_POS - 11'h001};
  localparam signed [TW-1:0] SAT_LO = {{(TW-`TMC_TEMP_W){1'b1}}, `TMC_CODE_NEG + 11'h001};
  wire signed [TW-1:0] raw_x;
  wire signed [TW-1:0] off_x;
  wire signed [TW-1:0] corrected;
  wire signed [TW-1:0] sat;
  wire fault_now;
  wire alarm_a;
  wire alarm_b;
  reg signed [AW-1:0] acc;
  reg signed [AW-1:0] next_acc;
  reg signed [AW-1:0] delta;
  reg primed;
  reg cmp_sample;
  reg signed [TW-1:0] cmp_temp;

  // Raw and offset widened so the sum cannot wrap
  assign raw_x = {{(TW-`TMC_TEMP_W){sample_in[`TMC_TEMP_W-1]}}, sample_in};
  assign off_x = {{(TW-`TMC_OFF_W){offset_in[`TMC_OFF_W-1]}}, offset_in};
  assign corrected = raw_x + off_x;
  // Clamp one step inside the fault codes so a real reading never mimics a fault
  assign sat = (corrected > SAT_HI) ? SAT_HI : (corrected < SAT_LO) ? SAT_LO : corrected;
  assign fault_now = (REMOTE != 0) && (diode_open_in || diode_short_in);

  // Exponential average: acc += (x - acc) >> k; primed loads the first sample so it starts at the reading
  always @* begin
    delta = {sat, {`TMC_ACC_FRAC{1'b0}}} - acc;
    case (average_coefficient_in)
      `TMC_AVE_8: next_acc = acc + (delta >>> `TMC_SHIFT_8);
      `TMC_AVE_16: next_acc = acc + (delta >>> `TMC_SHIFT_16);
      default: next_acc = {sat, {`TMC_ACC_FRAC{1'b0}}}; // Code 11 falls back to no averaging
    endcase
    if (!primed) begin
      next_acc = {sat, {`TMC_ACC_FRAC{1'b0}}};
    end
  end

  always @(posedge clock_in) begin
    if (!resetn_in || config_write_in) begin
      acc <= {AW{1'b0}};
      primed <= 1'b0;
      cmp_sample <= 1'b0;
      cmp_temp <= {TW{1'b0}};
      temperature_out <= `TMC_TEMP_RST;
      readout_valid_out <= 1'b0;
      fault_out <= 1'b0;
      alarm_comparator_a_out <= 1'b0;
      alarm_comparator_b_out <= 1'b0;
    end else begin
      cmp_sample <= sample_valid_in && !fault_now;
      cmp_temp <= corrected;
      readout_valid_out <= sample_valid_in;
      alarm_comparator_a_out <= alarm_a;
      alarm_comparator_b_out <= alarm_b;
      if (sample_valid_in) begin
        if (fault_now) begin
          fault_out <= 1'b1;
          // Short reads the positive code unless polarity is set
          if (diode_short_in ^ fault_read_polarity_in) begin
            temperature_out <= `TMC_CODE_POS;
          end else begin
            temperature_out <= `TMC_CODE_NEG;
          end
        end else begin
          fault_out <= 1'b0;
          acc <= next_acc;
          primed <= 1'b1;
          temperature_out <= next_acc[AW-3:`TMC_ACC_FRAC];
        end
      end
    end
  end

  // Comparators see the unaveraged corrected value; averaging applies to readout only
  tmc_alarm #(.TW(TW)) u_alarm_a (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .clear_in(config_write_in),
    .sample_in(cmp_sample),
    .temp_in(cmp_temp),
    .threshold_in(threshold_a_in),
    .hysteresis_in(hysteresis_a_in),
    .depth_code_in(alarm_filter_a_in),
    .alarm_out(alarm_a)
  );

  tmc_alarm #(.TW(TW)) u_alarm_b (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .clear_in(config_write_in),
    .sample_in(cmp_sample),
    .temp_in(cmp_temp),
    .threshold_in(threshold_b_in),
    .hysteresis_in(hysteresis_b_in),
    .depth_code_in(alarm_filter_b_in),
    .alarm_out(alarm_b)
  );
endmodule

// *** design/tmc_map.vh ***
`ifndef TMC_MAP_VH
`define TMC_MAP_VH
// Readout format: signed 11-bit, quarter degrees
`define TMC_TEMP_W 11
`define TMC_OFF_W 9
`define TMC_TH_W 9
`define TMC_HYST_W 7
`define TMC_FILT_W 4
// Threshold and hysteresis are whole degrees; shift by two to reach quarter degrees
`define TMC_DEG_SHIFT 2
// Diode fault readout codes
`define TMC_CODE_POS 11'h3ff
`define TMC_CODE_NEG 11'h401
// Averaging selector codes and shifts (coefficient 1, 8, 16)
`define TMC_AVE_1 2'h0
`define TMC_AVE_8 2'h1
`define TMC_AVE_16 2'h2
`define TMC_SHIFT_8 3
`define TMC_SHIFT_16 4
// Reset value and accumulator fraction bits
`define TMC_TEMP_RST 11'h000
`define TMC_ACC_FRAC 4
`endif

// *** sim/tmc_channel_monitor.sv ***
`timescale 1ns/100ps
module tmc_channel_monitor #(parameter REMOTE = 1) (
  input wire clock_in, // Clock
  input wire resetn_in, // Reset, active low
  input wire config_write_in, // Config write
  input wire sample_valid_in, // Sample strobe
  input wire [10:0] sample_in, // Raw sample
  input wire diode_open_in, // Open diode
  input wire diode_short_in, // Short diode
  input wire [8:0] offset_in, // Offset
  input wire fault_read_polarity_in, // Fault polarity
  input wire [1:0] average_coefficient_in, // Averaging
  input wire [10:0] temperature_out, // Readout
  input wire readout_valid_out, // Readout strobe
  input wire fault_out, // Fault flag
  input wire alarm_comparator_a_out, // Alarm A
  input wire alarm_comparator_b_out // Alarm B
);
  wire signed [11:0] corr = $signed(sample_in) + $signed(offset_in);
  wire take = resetn_in && !config_write_in && sample_valid_in;
  wire fault_read_polarity = (REMOTE != 0) && (diode_open_in || diode_short_in);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // Unaveraged path only, away from the clamp so the sum is exact
  sequence s_raw_take;
    take && !fault_read_polarity && average_coefficient_in == 2'h0 && corr > -12'sd1022 && corr < 12'sd1022;
  endsequence
  AST_OFFSET_SUM: assert property (s_raw_take |=> temperature_out == $past(corr[10:0]))
    else $error("readout is not sample plus offset");
  AST_READOUT_STROBE: assert property (readout_valid_out == $past(take))
    else $error("readout strobe not tied to sample");
  AST_HOLD: assert property (resetn_in && !config_write_in && !sample_valid_in |=> $stable(temperature_out))
    else $error("readout moved without sample");
  AST_SHORT_CODE: assert property (take && fault_read_polarity && diode_short_in |=> fault_out
    && temperature_out == ($past(fault_read_polarity_in) ? 11'h401 : 11'h3ff))
    else $error("wrong short code");
  AST_OPEN_CODE: assert property (take && fault_read_polarity && !diode_short_in |=> fault_out
    && temperature_out == ($past(fault_read_polarity_in) ? 11'h3ff : 11'h401))
    else $error("wrong open code");
  AST_NO_FAULT: assert property (take && !fault_read_polarity |=> !fault_out)
    else $error("fault flagged without diode fault");
  AST_CODE_UNIQUE: assert property (!fault_out |-> temperature_out != 11'h3ff && temperature_out != 11'h401)
    else $error("plain reading equals a fault code");
  AST_CFG_CLEAR: assert property (config_write_in |=> temperature_out == 11'h000 && !fault_out
    && !alarm_comparator_a_out && !alarm_comparator_b_out)
    else $error("config write left state");
  AST_ALARM_CAUSE: assert property ($rose(alarm_comparator_a_out) |-> $past(sample_valid_in, 3))
    else $error("alarm rose without sample");
endmodule
bind tmc_channel tmc_channel_monitor #(.REMOTE(REMOTE)) u_mon (.clock_in, .resetn_in, .config_write_in,
  .sample_valid_in, .sample_in, .diode_open_in, .diode_short_in, .offset_in, .fault_read_polarity_in,
  .average_coefficient_in, .temperature_out, .readout_valid_out, .fault_out, .alarm_comparator_a_out,
  .alarm_comparator_b_out);

// *** sim/tmc_channel_tb.sv ***
`timescale 1ns/100ps
module tmc_channel_tb;
  reg clock_in = 1'b0;
  reg resetn_in = 1'b0;
  reg config_write_in = 1'b0;
  reg fault_read_polarity_in = 1'b0;
  reg [8:0] offset_in = 9'h000;
  reg [8:0] threshold_a_in = 9'h001;
  reg [8:0] threshold_b_in = 9'h1c0;
  reg [1:0] average_coefficient_in = 2'h0;
  reg [3:0] alarm_filter_a_in = 4'h2;
  reg [3:0] alarm_filter_b_in = 4'h0;
  reg [6:0] hysteresis_a_in = 7'h7e;
  reg [6:0] hysteresis_b_in = 7'h00;
  wire sample_valid_in, diode_open_in, diode_short_in, readout_valid_out, fault_out, int_fault;
  wire alarm_comparator_a_out, alarm_comparator_b_out;
  wire [10:0] sample_in, temperature_out, int_temp;
  integer n_mismatch = 0;
  integer check_count = 0;
  integer cycles = 0;
  integer i;
  tmc_diode_model u_tmc_diode_model (.clock_in, .sample_valid_out(sample_valid_in), .sample_out(sample_in),
    .open_out(diode_open_in), .short_out(diode_short_in));
  tmc_channel u_tmc_channel (.*);
  tmc_channel #(.REMOTE(0)) u_tmc_channel_int (.*, .temperature_out(int_temp), .readout_valid_out(),
    .fault_out(int_fault), .alarm_comparator_a_out(), .alarm_comparator_b_out());
  always #10 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      n_mismatch = n_mismatch + 1;
      end_sim;
    end
  end
  task check(input [10:0] seen, input [10:0] want);
    begin
      check_count = check_count + 1;
      if (seen !== want) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  task cfg;
    begin
      @(negedge clock_in) config_write_in = 1'b1;
      @(negedge clock_in) config_write_in = 1'b0;
    end
  endtask
  task t_offset;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        offset_in = (i == 0) ? 9'h0ff : (i == 1) ? 9'h100 : 9'h1ff;
        u_tmc_diode_model.measure(11'h064, 1'b0, 1'b0);
        check(temperature_out, (i == 0) ? 11'h163 : (i == 1) ? 11'h764 : 11'h063);
        check(readout_valid_out, 11'h001);
      end
      // Sum beyond the readout range must stop one step short of the short code
      offset_in = 9'h0ff;
      u_tmc_diode_model.measure(11'h3ff, 1'b0, 1'b0);
      check(temperature_out, 11'h3fe);
      offset_in = 9'h000;
    end
  endtask
  task t_fault;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        fault_read_polarity_in = i[1];
        u_tmc_diode_model.measure(11'h064, i[0], !i[0]);
        check(temperature_out, (!i[0] ^ i[1]) ? 11'h3ff : 11'h401);
        check(fault_out, 11'h001);
        check(int_temp, 11'h064);
        check(int_fault, 11'h000);
      end
    end
  endtask
  task t_average;
    begin
      // Code 3 is not a legal setting; it must behave as coefficient 1
      for (i = 1; i < 4; i = i + 1) begin
        average_coefficient_in = i[1:0];
        cfg;
        u_tmc_diode_model.measure(11'h040, 1'b0, 1'b0);
        check(temperature_out, 11'h040);
        u_tmc_diode_model.measure(11'h080, 1'b0, 1'b0);
        check(temperature_out, (i == 3) ? 11'h080 : 11'h040 + (11'h040 >> (i + 2)));
      end
      average_coefficient_in = 2'h0;
    end
  endtask
  task t_alarm;
    begin
      cfg;
      for (i = 0; i < 9; i = i + 1) begin
        u_tmc_diode_model.measure((i < 3) ? 11'h010 : (i < 6) ? 11'h000 : 11'h7f8, 1'b0, 1'b0);
        repeat (4) @(negedge clock_in);
        check(alarm_comparator_a_out, (i >= 2 && i < 8));
        check(alarm_comparator_b_out, 11'h001);
      end
    end
  endtask
  task end_sim;
    begin
      if (n_mismatch == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(negedge clock_in);
    resetn_in = 1'b1;
    t_offset;
    t_fault;
    t_average;
    t_alarm;
    end_sim;
  end
endmodule

// *** sim/tmc_diode_model.sv ***
`timescale 1ns/100ps
module tmc_diode_model (
  input wire clock_in, // Clock
  output reg sample_valid_out, // Conversion strobe
  output reg [10:0] sample_out, // Converted value
  output reg open_out, // Diode open
  output reg short_out // Diode short
);
  initial {sample_valid_out, sample_out, open_out, short_out} = 14'h0;
  // Bus is inverted after the strobe so a stale value is never taken for fresh
  task measure(input [10:0] t, input o, input s);
    begin
      @(negedge clock_in);
      {sample_out, open_out, short_out, sample_valid_out} = {t, o, s, 1'b1};
      @(negedge clock_in);
      sample_valid_out = 1'b0;
      sample_out = ~t;
    end
  endtask
endmodule
